// File: hdl/cmpt_fmt_cfg.svh
`ifndef CMPT_FMT_CFG_SVH
`define CMPT_FMT_CFG_SVH
`define FMT_FIRST_OFS 12'hbc4
`define FMT_LAST_OFS 12'hbdc
`define CTRL_OFS 12'h000
`define RSIZE_OFS 12'h004
`define BASE_LO_OFS 12'h008
`define BASE_HI_OFS 12'h00c
`define INDEX_OFS 12'h010
`define STATE_OFS 12'h014
`define FMT_COLOR_LSB 0
`define FMT_ERR_LSB 16
`define SEL_NONE 3'h7
`define SIZE_SHIFT_BASE 3'h3
`define RSIZE_RESET 16'h0040
`define RSIZE_MIN 16'h0002
`endif

// File: hdl/cmpt_fmt_pkg.sv
`default_nettype none
package cmpt_fmt_pkg;
  typedef enum logic [2:0] {
    TRIG_DIS = 3'h0, TRIG_EVERY = 3'h1, TRIG_USER_COUNT = 3'h2, TRIG_USER = 3'h3,
    TRIG_USER_TIMER = 3'h4, TRIG_USER_TIMER_COUNT = 3'h5
  } trig_mode_t;
  typedef enum logic [1:0] {AWAITING_SERVICE = 2'h0, ARMED = 2'h1} phase_t;
  typedef enum logic [1:0] {
    FAULT_NONE = 2'h0, FAULT_BAD_CIDX = 2'h1, FAULT_DESC = 2'h2, FAULT_OVERFLOW = 2'h3
  } fault_t;
  typedef struct packed {
    logic [26:0] rsvd;
    fault_t fault;
    phase_t phase;
    logic color;
    logic [15:0] cidx;
    logic [15:0] pidx;
  } stat_rec_t;
  typedef struct packed {
    logic [511:0] data;
    logic [2:0] color_sel;
    logic [2:0] fault_sel;
    logic fault_bit;
    logic user_trig;
  } cmpt_pkt_t;
endpackage
`default_nettype wire

// File: hdl/cmpt_status_format.sv
// The Wishbone register port is this design's own decision.
`include "cmpt_fmt_cfg.svh"
`default_nettype none
module cmpt_status_format
  import cmpt_fmt_pkg::*;
#(
  parameter logic [6:0][8:0] COLOR_POS = {9'h1ff, 9'h0ff, 9'h07f, 9'h03f, 9'h1fe, 9'h0fe, 9'h07e},
  parameter logic [7:0][8:0] ERR_POS = {9'h1fd, 9'h0fd, 9'h07d, 9'h03d, 9'h1fc, 9'h0fc,
                                        9'h07c, 9'h03c}
)(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [11:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic CMPT_VALID,
  output logic CMPT_READY,
  input wire cmpt_pkt_t CMPT_PKT,
  input wire logic CIDX_VALID,
  input wire logic [15:0] CIDX_VALUE,
  input wire logic TIMER_EXPIRE,
  input wire logic DESC_FAULT,
  output logic ENTRY_VALID,
  input wire logic ENTRY_READY,
  output logic [63:0] ENTRY_ADDR,
  output logic [511:0] ENTRY_DATA,
  output logic STAT_VALID,
  input wire logic STAT_READY,
  output logic [63:0] STAT_ADDR,
  output stat_rec_t STAT_DATA
);

  // Queue context held in software-visible registers, then status request, bus and output stage registers
  logic stat_en_r;
  trig_mode_t mode_r;
  logic [1:0] size_code_r;
  logic [15:0] ring_size_r;
  logic [63:0] base_r;
  logic [15:0] pidx_r;
  logic [15:0] cidx_r;
  logic color_r;
  phase_t phase_r;
  fault_t fault_r;
  logic stat_pend_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic cmpt_ready_r;
  logic entry_valid_r;
  logic [63:0] entry_addr_r;
  logic [511:0] entry_data_r;
  logic stat_valid_r;
  logic [63:0] stat_addr_r;
  stat_rec_t stat_data_r;

  // Bus request decode
  logic wb_req;
  logic wb_wr;
  logic [11:0] adr;
  logic fmt_hit;
  logic [2:0] fmt_idx;
  logic [11:0] fmt_ofs;
  assign wb_req = WB_CYC_I && WB_STB_I && !ack_r;
  assign wb_wr = wb_req && WB_WE_I;
  assign adr = {WB_ADR_I[11:2], 2'b00};
  assign fmt_ofs = adr - `FMT_FIRST_OFS;
  assign fmt_hit = (adr >= `FMT_FIRST_OFS) && (adr <= `FMT_LAST_OFS);
  assign fmt_idx = fmt_ofs[4:2];

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        res[8*b +: 8] = nw[8*b +: 8];
    end
    return res;
  endfunction

  // Ring geometry
  logic [2:0] shift;
  logic [15:0] last_slot;
  logic [15:0] pidx_inc;
  logic pidx_wrap;
  assign shift = `SIZE_SHIFT_BASE + {1'b0, size_code_r};
  assign last_slot = ring_size_r - 16'h0001;
  assign pidx_wrap = (pidx_r + 16'h0001) >= last_slot;
  assign pidx_inc = pidx_wrap ? 16'h0000 : pidx_r + 16'h0001;

  // Events from the packet stream, index updates and timer
  logic accept;
  logic overflow;
  logic stored;
  logic cidx_bad;
  logic cidx_ok;
  logic timer_mode;
  logic user_mode;
  assign accept = CMPT_VALID && cmpt_ready_r;
  assign overflow = pidx_inc == cidx_r; // Last free slot kept empty to tell full from empty
  assign stored = accept && !overflow;
  assign cidx_bad = CIDX_VALID && (CIDX_VALUE >= last_slot);
  assign cidx_ok = CIDX_VALID && !cidx_bad;
  assign timer_mode = (mode_r == TRIG_USER_TIMER) || (mode_r == TRIG_USER_TIMER_COUNT);
  assign user_mode = (mode_r == TRIG_USER) || (mode_r == TRIG_USER_COUNT) || timer_mode;

  // Status write triggers under moderation
  logic pkt_trig;
  logic cidx_trig;
  logic timer_trig;
  logic armed_now;
  logic fire;
  assign pkt_trig = stored && ((mode_r == TRIG_EVERY) || (user_mode && CMPT_PKT.user_trig));
  assign cidx_trig = cidx_ok && (CIDX_VALUE != pidx_r) && (mode_r != TRIG_DIS);
  assign timer_trig = TIMER_EXPIRE && timer_mode && (pidx_r != cidx_r);
  assign armed_now = (phase_r == ARMED) || cidx_ok;
  assign fire = stat_en_r && armed_now && (pkt_trig || cidx_trig || timer_trig);

  // Entry formatting: size mask then selected bit overwrite
  logic [511:0] fmt_data;
  always_comb
  begin
    fmt_data = CMPT_PKT.data;
    for (int i = 0; i < 512; i++)
    begin
      if (i >= (64 << size_code_r))
        fmt_data[i] = 1'b0;
    end
    if (CMPT_PKT.color_sel != `SEL_NONE)
      fmt_data[COLOR_POS[CMPT_PKT.color_sel]] = color_r;
    if (CMPT_PKT.fault_sel != `SEL_NONE)
      fmt_data[ERR_POS[CMPT_PKT.fault_sel]] = CMPT_PKT.fault_bit;
  end

  // Bus acknowledge, one cycle after request
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      ack_r <= 1'b0;
    else if (CE)
      ack_r <= wb_req;
  end

  // Read mux; unmapped words read zero
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      rdata_r <= 32'h0000_0000;
    else if (CE && wb_req)
    begin
      rdata_r <= 32'h0000_0000;
      if (fmt_hit)
      begin
        rdata_r[`FMT_COLOR_LSB +: 9] <= COLOR_POS[fmt_idx];
        rdata_r[`FMT_ERR_LSB +: 9] <= ERR_POS[fmt_idx];
      end
      else
      begin
        unique case (adr)
          `CTRL_OFS: rdata_r <= {26'h0, size_code_r, mode_r, stat_en_r};
          `RSIZE_OFS: rdata_r <= {16'h0, ring_size_r};
          `BASE_LO_OFS: rdata_r <= base_r[31:0];
          `BASE_HI_OFS: rdata_r <= base_r[63:32];
          `INDEX_OFS: rdata_r <= {cidx_r, pidx_r};
          `STATE_OFS: rdata_r <= {27'h0, fault_r, phase_r, color_r};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software-owned context fields; format words have no writable state
  logic [31:0] ctrl_w;
  assign ctrl_w = merge({26'h0, size_code_r, mode_r, stat_en_r}, WB_DAT_I, WB_SEL_I);
  // Upper half of the ring size word is reserved, only the low half is kept
  logic [31:0] rsize_w;
  assign rsize_w = merge({16'h0, ring_size_r}, WB_DAT_I, WB_SEL_I);
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      stat_en_r <= 1'b0;
      mode_r <= TRIG_DIS;
      size_code_r <= 2'h0;
      ring_size_r <= `RSIZE_RESET;
      base_r <= 64'h0;
    end
    else if (CE && wb_wr && !fmt_hit)
    begin
      unique case (adr)
        `CTRL_OFS:
        begin
          stat_en_r <= ctrl_w[0];
          mode_r <= trig_mode_t'(ctrl_w[3:1]);
          size_code_r <= ctrl_w[5:4];
        end
        `RSIZE_OFS:
        begin
          // Below two slots the ring cannot hold an entry and the status
          ring_size_r <= (rsize_w[15:0] < `RSIZE_MIN) ? `RSIZE_MIN : rsize_w[15:0];
        end
        `BASE_LO_OFS: base_r[31:0] <= {merge(base_r[31:0], WB_DAT_I, WB_SEL_I)};
        `BASE_HI_OFS: base_r[63:32] <= merge(base_r[63:32], WB_DAT_I, WB_SEL_I);
        default:
        begin
        end
      endcase
    end
  end

  // Producer index and ring color; color flips on each wrap
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      pidx_r <= 16'h0;
      color_r <= 1'b1;
    end
    else if (CE && stored)
    begin
      pidx_r <= pidx_inc;
      if (pidx_wrap)
        color_r <= !color_r;
    end
  end

  // Consumer index copy
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      cidx_r <= 16'h0;
    else if (CE && cidx_ok)
      cidx_r <= CIDX_VALUE;
  end

  // Fault code is sticky until reset, like the context field
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      fault_r <= FAULT_NONE;
    else if (CE && fault_r == FAULT_NONE)
    begin
      if (accept && overflow)
        fault_r <= FAULT_OVERFLOW;
      else if (DESC_FAULT)
        fault_r <= FAULT_DESC;
      else if (cidx_bad)
        fault_r <= FAULT_BAD_CIDX;
    end
  end

  // One outstanding status per arming; an index update re-arms
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      phase_r <= ARMED;
    else if (CE)
    begin
      if (fire)
        phase_r <= AWAITING_SERVICE;
      else if (cidx_ok)
        phase_r <= ARMED;
    end
  end

  // Entry output stage; input ready only while stage is free
  logic entry_valid_nxt;
  assign entry_valid_nxt = stored || (entry_valid_r && !ENTRY_READY);
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      entry_valid_r <= 1'b0;
      cmpt_ready_r <= 1'b0;
      entry_addr_r <= 64'h0;
      entry_data_r <= 512'h0;
    end
    else if (CE)
    begin
      entry_valid_r <= entry_valid_nxt;
      cmpt_ready_r <= !entry_valid_nxt && !accept;
      if (stored)
      begin
        entry_addr_r <= base_r + ({48'h0, pidx_r} << shift);
        entry_data_r <= fmt_data;
      end
    end
  end

  // Status request latch; set wins over the issue clear
  logic stat_issue;
  assign stat_issue = stat_pend_r && (!stat_valid_r || STAT_READY);
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      stat_pend_r <= 1'b0;
    else if (CE)
    begin
      if (fire)
        stat_pend_r <= 1'b1;
      else if (stat_issue)
        stat_pend_r <= 1'b0;
    end
  end

  // Status record output, built from live context when issued
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      stat_valid_r <= 1'b0;
      stat_addr_r <= 64'h0;
      stat_data_r <= '0;
    end
    else if (CE)
    begin
      if (stat_issue)
      begin
        stat_valid_r <= 1'b1;
        stat_addr_r <= base_r + ({48'h0, last_slot} << shift);
        stat_data_r.rsvd <= 27'h0;
        stat_data_r.fault <= fault_r;
        stat_data_r.phase <= phase_r;
        stat_data_r.color <= color_r;
        stat_data_r.cidx <= cidx_r;
        stat_data_r.pidx <= pidx_r;
      end
      else if (STAT_READY)
        stat_valid_r <= 1'b0;
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdata_r;
  assign CMPT_READY = cmpt_ready_r;
  assign ENTRY_VALID = entry_valid_r;
  assign ENTRY_ADDR = entry_addr_r;
  assign ENTRY_DATA = entry_data_r;
  assign STAT_VALID = stat_valid_r;
  assign STAT_ADDR = stat_addr_r;
  assign STAT_DATA = stat_data_r;

  // Checks; frozen cycles are excluded since state holds still
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST || !CE);

  stat_needs_enable_a: assert property (
    $rose(stat_pend_r) |-> $past(stat_en_r))
    else $error("status requested while disabled");

  stat_slot_last_a: assert property (
    $rose(stat_valid_r) |-> stat_addr_r == base_r + ({48'h0, last_slot} << shift))
    else $error("status address not last slot");

  phase_blocks_a: assert property (
    (phase_r == AWAITING_SERVICE && !CIDX_VALID) |-> !fire)
    else $error("status fired while awaiting service");

  pkt_every_a: assert property (
    (stored && mode_r == TRIG_EVERY && stat_en_r && phase_r == ARMED) |=> stat_pend_r)
    else $error("stored packet did not request status");

  cidx_trig_a: assert property (
    (cidx_ok && stat_en_r && mode_r != TRIG_DIS && CIDX_VALUE != pidx_r)
    |=> stat_pend_r ##1 stat_valid_r || stat_valid_r)
    else $error("index update with entries left gave no status");

  timer_mode_a: assert property (
    (TIMER_EXPIRE && !timer_mode && !CIDX_VALID && !CMPT_VALID) |-> !fire)
    else $error("timer fired outside timer mode");

  overflow_code_a: assert property (
    (accept && overflow && fault_r == FAULT_NONE) |=> fault_r == FAULT_OVERFLOW ##1
    fault_r == FAULT_OVERFLOW)
    else $error("overflow not reported");

  record_fields_a: assert property (
    $rose(stat_valid_r) |-> stat_data_r.rsvd == 27'h0 && stat_data_r.pidx == $past(pidx_r))
    else $error("record fields wrong");

  color_place_a: assert property (
    (stored && CMPT_PKT.color_sel != `SEL_NONE)
    |=> entry_data_r[COLOR_POS[$past(CMPT_PKT.color_sel)]] == $past(color_r))
    else $error("color bit misplaced");

  untouched_a: assert property (
    (stored && CMPT_PKT.color_sel == `SEL_NONE && CMPT_PKT.fault_sel == `SEL_NONE
     && size_code_r == 2'h3) |=> entry_data_r == $past(CMPT_PKT.data))
    else $error("data changed with no bits selected");

  fmt_readonly_a: assert property (
    (wb_wr && fmt_hit) |=> $stable(stat_en_r) && $stable(ring_size_r) && $stable(base_r))
    else $error("format write changed state");

  wb_ack_pulse_a: assert property (
    ack_r |=> !ack_r)
    else $error("ack longer than one cycle");

  cover_pkt_stat_c: cover property (stored ##1 stat_pend_r ##1 stat_valid_r);
  cover_wrap_c: cover property (stored && pidx_wrap);
  cover_fmt_read_c: cover property (wb_req && fmt_hit && !WB_WE_I);
  cover_timer_c: cover property (timer_trig && fire);

endmodule
`default_nettype wire

// File: tb/cmpt_src_model.sv
`default_nettype none
module cmpt_src_model
  import cmpt_fmt_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic CMPT_READY,
  output logic CMPT_VALID,
  output var cmpt_pkt_t CMPT_PKT
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle until the first packet
  initial
  begin
    CMPT_VALID = 1'b0;
    CMPT_PKT = '0;
  end

  // One whole beat per packet, held until the taking edge
  task automatic send(input cmpt_pkt_t p);
    @(posedge REF_CLK);
    CMPT_VALID <= 1'b1;
    CMPT_PKT <= p;
    do @(posedge REF_CLK); while (CMPT_READY !== 1'b1);
    CMPT_VALID <= 1'b0;
    // Inverse after release, so a late sample cannot pass for the old beat
    CMPT_PKT <= ~p;
  endtask
endmodule
`default_nettype wire

// File: tb/completion_status_entry_format_tb.sv
`include "cmpt_fmt_cfg.svh"
`default_nettype none
module completion_status_entry_format_tb
  import cmpt_fmt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // Positions kept below 64 so every entry size holds them
  localparam logic [6:0][8:0] CPOS = {9'h03e, 9'h030, 9'h02a, 9'h020, 9'h018, 9'h010, 9'h008};
  localparam logic [7:0][8:0] EPOS = {9'h03f, 9'h031, 9'h02b, 9'h021, 9'h019, 9'h011, 9'h009,
                                      9'h001};
  localparam logic [511:0] DATA = {16{32'ha5a5_5a5a}};
  localparam logic [63:0] BASE = 64'h1000;
  localparam int CODE = 1;
  localparam int RSIZE = 8;
  logic ref_clk = 1'b0;
  logic rst, cyc, stb, we, ack, cidx_v, tmr, dflt, ent_rdy, st_rdy, cvalid, cready, ent_v, st_v;
  logic [11:0] adr;
  logic [31:0] wdat, wdo, rdat;
  logic [15:0] cidx_val;
  logic [63:0] ent_a, st_a, ea, sa;
  logic [511:0] ent_d, ed;
  cmpt_pkt_t pkt;
  stat_rec_t st_d, sd;
  int num_errors = 0;
  int tests_run = 0;
  int ent_cnt = 0;
  int st_cnt = 0;

  always #2.5 ref_clk = ~ref_clk;

  cmpt_status_format #(.COLOR_POS(CPOS), .ERR_POS(EPOS)) i_dut (
    .REF_CLK(ref_clk), .RST(rst), .CE(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(wdo), .WB_ACK_O(ack),
    .CMPT_VALID(cvalid), .CMPT_READY(cready), .CMPT_PKT(pkt), .CIDX_VALID(cidx_v),
    .CIDX_VALUE(cidx_val), .TIMER_EXPIRE(tmr), .DESC_FAULT(dflt), .ENTRY_VALID(ent_v),
    .ENTRY_READY(ent_rdy), .ENTRY_ADDR(ent_a), .ENTRY_DATA(ent_d), .STAT_VALID(st_v),
    .STAT_READY(st_rdy), .STAT_ADDR(st_a), .STAT_DATA(st_d));

  cmpt_src_model i_src (.REF_CLK(ref_clk), .CMPT_READY(cready), .CMPT_VALID(cvalid),
    .CMPT_PKT(pkt));

  // Capture every completed write toward host memory
  always @(posedge ref_clk)
  begin
    if (ent_v && ent_rdy)
    begin
      ed <= ent_d;
      ea <= ent_a;
      ent_cnt <= ent_cnt + 1;
    end
    if (st_v && st_rdy)
    begin
      sd <= st_d;
      sa <= st_a;
      st_cnt <= st_cnt + 1;
    end
  end

  task automatic chk(input string nm, input logic [511:0] seen, input logic [511:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    if (num_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Classic single cycle; the next call's first edge gives the idle cycle
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge ref_clk); while (ack !== 1'b1);
    rdat = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic pulse_tmr();
    @(posedge ref_clk);
    tmr <= 1'b1;
    @(posedge ref_clk);
    tmr <= 1'b0;
  endtask

  task automatic pulse_cidx(input logic [15:0] v);
    @(posedge ref_clk);
    cidx_v <= 1'b1;
    cidx_val <= v;
    @(posedge ref_clk);
    cidx_v <= 1'b0;
  endtask

  // Expected entry worked out from size code and selected positions
  task automatic send_chk(input logic [2:0] cs, input logic [2:0] fs, input logic fb, input int k);
    cmpt_pkt_t p;
    logic [511:0] e;
    int n;
    p = '{data: DATA, color_sel: cs, fault_sel: fs, fault_bit: fb, user_trig: 1'b0};
    e = DATA & ((512'h1 << (64 << CODE)) - 512'h1);
    if (cs != 3'h7)
      e[CPOS[cs]] = 1'b1;
    if (fs != 3'h7)
      e[EPOS[fs]] = fb;
    n = ent_cnt;
    i_src.send(p);
    for (int i = 0; i < 20 && ent_cnt == n; i++)
      @(posedge ref_clk);
    chk("entry data", ed, e);
    chk("entry addr", ea, BASE + (64'(k) << (3 + CODE)));
  endtask

  task automatic stat_chk(input int c, input logic [15:0] pi, input logic [15:0] ci);
    for (int i = 0; i < 20 && st_cnt < c; i++)
      @(posedge ref_clk);
    chk("stat count", 512'(st_cnt), 512'(c));
    chk("stat addr", sa, BASE + (64'(RSIZE - 1) << (3 + CODE)));
    chk("stat phase", sd[34:33], AWAITING_SERVICE);
    chk("stat fields", {sd[63:35], sd[32:0]}, {27'h0, FAULT_NONE, 1'b1, ci, pi});
  endtask

  // No status may appear within a span well past its answer time
  task automatic quiet(input int c);
    repeat (10) @(posedge ref_clk);
    chk("stat count", 512'(st_cnt), 512'(c));
  endtask

  task automatic t_regs();
    for (int n = 0; n < 7; n++)
    begin
      wb(1'b0, `FMT_FIRST_OFS + 12'(4 * n), 32'h0);
      chk("format reg", rdat, {7'h0, EPOS[n], 7'h0, CPOS[n]});
    end
    wb(1'b1, `FMT_LAST_OFS, 32'hffff_ffff);
    wb(1'b0, `FMT_LAST_OFS, 32'h0);
    chk("format ro", rdat, {7'h0, EPOS[6], 7'h0, CPOS[6]});
    wb(1'b0, 12'h800, 32'h0);
    chk("unmapped", rdat, 32'h0);
    wb(1'b0, `RSIZE_OFS, 32'h0);
    chk("ring size", rdat, 32'h40);
    wb(1'b0, `STATE_OFS, 32'h0);
    chk("state", rdat, 32'h3);
    wb(1'b1, `RSIZE_OFS, 32'(RSIZE));
    wb(1'b1, `BASE_LO_OFS, BASE[31:0]);
  endtask

  task automatic t_moderation();
    wb(1'b1, `CTRL_OFS, 32'h11);
    send_chk(3'h0, 3'h1, 1'b1, 0);
    // Expiry outside a timer mode must not raise a status
    pulse_tmr();
    quiet(0);
    wb(1'b1, `CTRL_OFS, 32'h12);
    send_chk(3'h1, 3'h2, 1'b0, 1);
    quiet(0);
  endtask

  task automatic t_status();
    wb(1'b1, `CTRL_OFS, 32'h13);
    send_chk(3'h2, 3'h3, 1'b1, 2);
    stat_chk(1, 16'h3, 16'h0);
    wb(1'b0, `STATE_OFS, 32'h0);
    chk("phase", rdat, 32'h1);
    send_chk(3'h7, 3'h7, 1'b1, 3);
    quiet(1);
    pulse_cidx(16'h2);
    stat_chk(2, 16'h4, 16'h2);
  endtask

  // Update with status off only re-arms, so the timer alone must raise the status
  task automatic t_timer();
    int n;
    wb(1'b1, `CTRL_OFS, 32'h18);
    n = st_cnt;
    pulse_cidx(16'h3);
    quiet(n);
    wb(1'b1, `CTRL_OFS, 32'h19);
    pulse_tmr();
    stat_chk(n + 1, 16'h4, 16'h3);
  endtask

  // Fault code is sticky, so a later descriptor fault must not replace it
  task automatic t_fault();
    pulse_cidx(16'h7);
    wb(1'b0, `STATE_OFS, 32'h0);
    chk("fault", rdat[4:3], FAULT_BAD_CIDX);
    dflt <= 1'b1;
    @(posedge ref_clk);
    dflt <= 1'b0;
    wb(1'b0, `STATE_OFS, 32'h0);
    chk("fault", rdat[4:3], FAULT_BAD_CIDX);
  endtask

  // Mid-run reset; a two-slot ring has no free entry slot, so the packet overflows
  task automatic t_overflow();
    int n;
    cmpt_pkt_t p;
    p = '{data: DATA, color_sel: 3'h7, fault_sel: 3'h7, fault_bit: 1'b0, user_trig: 1'b0};
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    wb(1'b1, `RSIZE_OFS, 32'h2);
    n = ent_cnt;
    i_src.send(p);
    wb(1'b0, `STATE_OFS, 32'h0);
    chk("overflow", rdat[4:3], FAULT_OVERFLOW);
    chk("dropped", 512'(ent_cnt), 512'(n));
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    {cyc, stb, we, cidx_v, tmr, dflt} = '0;
    adr = '0;
    wdat = '0;
    cidx_val = '0;
    ent_rdy = 1'b1;
    st_rdy = 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_moderation();
    t_status();
    t_timer();
    t_fault();
    t_overflow();
    close_out();
  end

  // Far beyond the few hundred cycles the sequence needs
  initial
  begin
    #200000;
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
